//--- dv/mcff_bank_checker.sv
/* Port assertions of the mode control and event flag bank.
   Assumes the bind below attaches it to every bank instance. */
`timescale 1ns/1ps
`default_nettype none
module mcff_bank_checker #(
    parameter int unsigned GAP_CYC = 20
)
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic short_detect,
    input wire logic main_sensor_input,
    input wire logic all_leds_off,
    input wire logic gain_up_req,
    input wire logic gain_down_req,
    input wire logic irq_out,
    input wire logic active_not_standby,
    input wire logic core_enable,
    input wire logic backlight_run,
    input wire logic dim_run,
    input wire logic gain_step_up,
    input wire logic gain_step_down
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    logic retrig_q;
    logic retrig_d;
    // Retrigger bit shadowed here, the bank keeps it internal
    always_comb retrig_d = (reg_wr && reg_addr == 8'h01) ?
        reg_wdata[6] : retrig_q;
    always_ff @(posedge clk_sys) retrig_q <= rst_b ? retrig_d : 1'b0;
    sequence mode_wr_s;
        reg_wr && reg_addr == 8'h01;
    endsequence
    sequence flag_rd_s;
        reg_rd && reg_addr == 8'h02;
    endsequence
    sequence clear_try_s;
        irq_out && reg_wr && reg_addr == 8'h02 && reg_wdata != 8'h00 && retrig_q;
    endsequence
    a_active_write: assert property (mode_wr_s |=>
        active_not_standby == $past(reg_wdata[5])) else $error("active bit");
    a_bl_write: assert property (mode_wr_s |=> backlight_run ==
        ($past(reg_wdata[0]) && $past(reg_wdata[5]))) else $error("backlight");
    a_dim_gate: assert property (dim_run |-> backlight_run)
        else $error("dim without backlight");
    a_down_gate: assert property (gain_step_down |->
        gain_down_req && core_enable) else $error("gain down");
    a_down_free: assert property (core_enable && gain_down_req &&
        all_leds_off |-> gain_step_down) else $error("gain down held");
    a_up_free: assert property (core_enable && gain_up_req |->
        gain_step_up) else $error("gain up held");
    a_mode_resv: assert property (reg_rd && reg_addr == 8'h01 |=>
        !reg_rdata[7]) else $error("reserved mode bit");
    a_short_sets: assert property (short_detect ##2 flag_rd_s |=>
        reg_rdata[4]) else $error("short flag");
    a_main_sets: assert property ($changed(main_sensor_input) ##2
        flag_rd_s |=> reg_rdata[0]) else $error("main sensor flag");
    a_gap_low: assert property (clear_try_s |-> ##2 !irq_out [*6])
        else $error("retrigger gap");
endmodule
bind mcff_bank mcff_bank_checker #(.GAP_CYC(GAP_CYC)) chk_u (.*);
`default_nettype wire

//--- dv/mcff_host_model.sv
/* Host side register master of the bank.
   Assumes its tasks are called from one bench process. */
`timescale 1ns/1ps
`default_nettype none
module mcff_host_model (
    input wire logic clk_sys,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // Flags clear only where a one is written
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1 d = reg_rdata;
    endtask
endmodule
`default_nettype wire

//--- dv/mode_control_and_fault_flags_bench.sv
/* Self-checking bench of the mode control and event flag bank.
   Assumes the host model and the checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module mode_control_and_fault_flags_bench;
    localparam int GAP = 20;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [2:0] det = 3'h0;
    logic [1:0] sens = 2'h0;
    logic level_two_compare_out = 1'b0;
    logic level_three_compare_out = 1'b0;
    logic dim_timeout = 1'b0;
    logic all_leds_off = 1'b0;
    logic gain_up_req = 1'b0;
    logic gain_down_req = 1'b0;
    logic reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, mode_m;
    logic irq_out, active_not_standby, core_enable, backlight_run, dim_run;
    logic gain_step_up, gain_step_down, independent_sink_run;
    logic [1:0] level_run;
    int fail_count = 0;
    int tests_run = 0;
    int flag_m = 0;
    int cnt;
    integer seed = 32'ha09926ac;
    always #5 clk_sys = ~clk_sys;
    mcff_host_model host_u (.*);
    mcff_bank #(.GAP_CYC(GAP)) dut_u (.*, .short_detect(det[2]),
        .thermal_detect(det[1]), .overvolt_detect(det[0]),
        .main_sensor_input(sens[0]), .second_sensor_input(sens[1]));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            $display("Error %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        host_u.rd(a, rv);
        chk(rv, e);
    endtask
    // Bit 4..2 are level detectors, 1..0 comparators that flag on change
    task automatic pulse(input int i);
        @(posedge clk_sys);
        if (i >= 2)
            det[i-2] <= 1'b1;
        else
            sens[i] <= ~sens[i];
        @(posedge clk_sys);
        det <= 3'h0;
        flag_m |= 1 << i;
    endtask
    task automatic gain(input logic [2:0] p, input logic [1:0] e);
        @(posedge clk_sys);
        {all_leds_off, gain_up_req, gain_down_req} <= p;
        settle(1);
        chk({gain_step_up, gain_step_down}, e);
    endtask
    task automatic mode_sink(input logic [7:0] s, input logic [7:0] m);
        host_u.wr(8'h10, s);
        host_u.wr(8'h01, m);
        settle(2);
    endtask
    task report_and_stop;
        if (fail_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        #50000;
        fail_count++;
        report_and_stop();
    end
    initial
    begin
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        rdchk(8'h01, 8'h00);
        rdchk(8'h02, 8'h00);
        for (int k = 0; k < 6; k++)
        begin
            rv = 8'($random(seed));
            host_u.wr(8'h01, rv);
            mode_m = rv & 8'h7f;
            mode_m[4] = mode_m[4] & mode_m[0];
            settle(2);
            chk(backlight_run, mode_m[0] & mode_m[5]);
            chk(dim_run, mode_m[4] & mode_m[5]);
            chk(active_not_standby, mode_m[5]);
            chk(core_enable, mode_m[5]);
            chk(independent_sink_run, mode_m[2] & mode_m[5]);
            rdchk(8'h01, mode_m);
        end
        host_u.wr(8'h01, 8'h28);
        gain(3'b011, 2'b10);
        gain(3'b111, 2'b11);
        host_u.wr(8'h01, 8'h20);
        gain(3'b011, 2'b11);
        mode_sink(8'h00, 8'h20);
        mode_sink(8'h01, 8'h24);
        chk(independent_sink_run, 1'b0);
        mode_sink(8'h00, 8'h24);
        chk(independent_sink_run, 1'b1);
        mode_sink(8'h02, 8'h20);
        chk(independent_sink_run, 1'b1);
        mode_sink(8'h00, 8'h20);
        chk(independent_sink_run, 1'b0);
        host_u.wr(8'h01, 8'h21);
        @(posedge clk_sys);
        dim_timeout <= 1'b1;
        @(posedge clk_sys);
        dim_timeout <= 1'b0;
        settle(2);
        chk(dim_run, 1'b1);
        rdchk(8'h01, 8'h31);
        host_u.wr(8'h04, 8'h08);
        settle(2);
        chk(level_run, 2'b01);
        host_u.wr(8'h1b, 8'h03);
        host_u.wr(8'h01, 8'h22);
        @(posedge clk_sys);
        {level_three_compare_out, level_two_compare_out} <= 2'b11;
        settle(3);
        chk(level_run, 2'b10);
        rdchk(8'h04, 8'h10);
        @(posedge clk_sys);
        {level_three_compare_out, level_two_compare_out} <= 2'b01;
        settle(3);
        chk(level_run, 2'b01);
        for (int i = 0; i < 5; i++)
        begin
            pulse(i);
            rdchk(8'h02, 8'(flag_m));
            host_u.wr(8'h02, 8'h00);
            rdchk(8'h02, 8'(flag_m));
            chk(irq_out, 1'b0);
            host_u.wr(8'h02, 8'(flag_m));
            flag_m = 0;
            rdchk(8'h02, 8'h00);
        end
        host_u.wr(8'h03, 8'h1f);
        host_u.wr(8'h01, 8'h20);
        pulse(4);
        pulse(3);
        settle(2);
        chk(irq_out, 1'b1);
        host_u.wr(8'h02, 8'h10);
        for (int k = 0; k < 4; k++)
        begin
            settle(1);
            chk(irq_out, 1'b1);
        end
        host_u.wr(8'h02, 8'h08);
        settle(3);
        chk(irq_out, 1'b0);
        host_u.wr(8'h01, 8'h60);
        pulse(4);
        pulse(2);
        settle(2);
        host_u.wr(8'h02, 8'h10);
        cnt = 0;
        #1;
        repeat (GAP + 10)
        begin
            if (irq_out === 1'b0)
                cnt++;
            settle(1);
        end
        chk(cnt >= GAP && cnt <= GAP + 1, 1'b1);
        chk(irq_out, 1'b1);
        host_u.wr(8'h03, 8'h1b);
        settle(3);
        chk(irq_out, 1'b0);
        rdchk(8'h02, 8'h04);
        report_and_stop();
    end
endmodule
`default_nettype wire

//--- src/mcff_bank.sv
/*
 * Mode control and event flag register bank of an LED driver.
 * Assumes the serial interface decoder hands over one byte access per
 * strobe, with a read data byte expected in the following cycle.
 */
// Summary of operation
// - Retrigger set: interrupt drops 50 us on clear try, back if pending.
// - Retrigger clear: interrupt stays asserted while events pend.
// - Active bit one runs device; zero is standby, serial port only.
// - Dim timeout expiry sets dim bit in hardware while backlight enabled.
// - Host may set dim bit; dim works only with backlight enabled.
// - Step-down inhibit: gain rises freely, falls only with LEDs off.
// - Inhibit clear: pump gain moves up and down with load.
// - Sync sink bit one turns independent sinks on, no per-sink enables.
// - Sync sink bit zero turns them off; ignored if per-sink enable set.
// - Auto level follows level two/three comparators when enabled.
// - Auto level off: backlight uses host brightness level field.
// - Backlight runs only when enabled and active.
// - Short-circuit detection sets the short flag.
// - Overtemperature detection sets the thermal flag.
// - Overvoltage detection sets the overvoltage flag.
// - Second comparator change sets second sensor flag.
// - Main comparator change sets main sensor flag.
// - Writing one clears a flag; zero writes and reads leave it.
// - Flags reach interrupt only when enabled; flags still set.
// - Auto level writes the brightness field, overwriting host value.
`timescale 1ns/1ps
`default_nettype none
`include "mcff_defs.svh"
module mcff_bank
    import mcff_pkg::*;
#(
    parameter int unsigned GAP_CYC = `MCFF_GAP_CYC
)
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic short_detect,
    input wire logic thermal_detect,
    input wire logic overvolt_detect,
    input wire logic main_sensor_input,
    input wire logic second_sensor_input,
    input wire logic level_two_compare_out,
    input wire logic level_three_compare_out,
    input wire logic dim_timeout,
    input wire logic all_leds_off,
    input wire logic gain_up_req,
    input wire logic gain_down_req,
    output logic irq_out,
    output logic active_not_standby,
    output logic core_enable,
    output logic backlight_run,
    output logic dim_run,
    output logic [1:0] level_run,
    output logic gain_step_up,
    output logic gain_step_down,
    output logic independent_sink_run
);
    mcff_byte_t mode_q, mode_d;
    mcff_byte_t irq_en_q, irq_en_d;
    mcff_byte_t cfg_q, cfg_d;
    mcff_byte_t sink_q, sink_d;
    mcff_byte_t ccfg_q, ccfg_d;
    mcff_byte_t rdata_q, rdata_d;
    logic main_q, second_q, sync_q, sync_d;
    mcff_flags_t evt;
    mcff_flags_t clr;
    logic clear_try;
    logic auto_on;
    mcff_level_t auto_level;
    mcff_flag_if fl_if ();

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    assign auto_on = mode_q[`MCFF_BIT_AUTO] && (ccfg_q[1:0] != 2'b00);
    // Level three wins when both comparators trip: darkest level
    assign auto_level = level_three_compare_out ? 2'b10 :
                        level_two_compare_out ? 2'b01 : 2'b00;

    always_comb
    begin
        mode_d = mode_q;
        irq_en_d = irq_en_q;
        cfg_d = cfg_q;
        sink_d = sink_q;
        ccfg_d = ccfg_q;
        sync_d = sync_q;
        clr = 5'h00;
        clear_try = 1'b0;
        if (reg_wr)
        begin
            if (hit(reg_addr, `MCFF_OFS_MODE))
            begin
                mode_d = reg_wdata & `MCFF_MODE_MASK;
                // Sync bit acts only with no per-sink enable set
                if (sink_q[6:0] == 7'h00)
                    sync_d = reg_wdata[`MCFF_BIT_SYNC];
            end
            if (hit(reg_addr, `MCFF_OFS_FLAG))
            begin
                clr = reg_wdata[4:0];
                clear_try = (reg_wdata[4:0] != 5'h00);
            end
            if (hit(reg_addr, `MCFF_OFS_IRQ_EN))
                irq_en_d = reg_wdata & `MCFF_FLAG_MASK;
            if (hit(reg_addr, `MCFF_OFS_CFG))
                cfg_d = reg_wdata & 8'h7f;
            if (hit(reg_addr, `MCFF_OFS_SINK))
                sink_d = reg_wdata & 8'h7f;
            if (hit(reg_addr, `MCFF_OFS_CCFG))
                ccfg_d = reg_wdata & 8'h03;
        end
        if (dim_timeout && mode_q[`MCFF_BIT_BL_ON])
            mode_d[`MCFF_BIT_DIM] = 1'b1;
        if (!mode_d[`MCFF_BIT_BL_ON])
            mode_d[`MCFF_BIT_DIM] = 1'b0;
        if (auto_on)
            cfg_d[4:3] = auto_level;
    end

    always_comb
    begin
        rdata_d = rdata_q;
        if (reg_rd)
        begin
            case (reg_addr)
                `MCFF_OFS_MODE: rdata_d = mode_q;
                `MCFF_OFS_FLAG: rdata_d = {3'b000, fl_if.flags};
                `MCFF_OFS_IRQ_EN: rdata_d = irq_en_q;
                `MCFF_OFS_CFG: rdata_d = cfg_q;
                `MCFF_OFS_SINK: rdata_d = sink_q;
                `MCFF_OFS_CCFG: rdata_d = ccfg_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_comb
    begin
        evt[4] = short_detect;
        evt[3] = thermal_detect;
        evt[2] = overvolt_detect;
        evt[1] = second_sensor_input ^ second_q;
        evt[0] = main_sensor_input ^ main_q;
    end

    assign fl_if.evt = evt;
    assign fl_if.clr = clr;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            mode_q <= `MCFF_MODE_RST;
            irq_en_q <= `MCFF_IRQ_EN_RST;
            cfg_q <= `MCFF_CFG_RST;
            sink_q <= `MCFF_SINK_RST;
            ccfg_q <= `MCFF_CCFG_RST;
            rdata_q <= 8'h00;
            sync_q <= 1'b0;
            main_q <= 1'b0;
            second_q <= 1'b0;
        end
        else
        begin
            mode_q <= mode_d;
            irq_en_q <= irq_en_d;
            cfg_q <= cfg_d;
            sink_q <= sink_d;
            ccfg_q <= ccfg_d;
            rdata_q <= rdata_d;
            sync_q <= sync_d;
            main_q <= main_sensor_input;
            second_q <= second_sensor_input;
        end
    end

    mcff_flag_unit u_flags (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .fl(fl_if.unit)
    );

    mcff_irq_timer #(.GAP_CYC(GAP_CYC)) u_irq (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .pending(|(fl_if.flags & irq_en_q[4:0])),
        .clear_try(clear_try),
        .retrigger(mode_q[`MCFF_BIT_RETRIG]),
        .irq(irq_out)
    );

    assign reg_rdata = rdata_q;
    assign active_not_standby = mode_q[`MCFF_BIT_ACT];
    // Standby keeps only the serial interface alive
    assign core_enable = mode_q[`MCFF_BIT_ACT];
    assign backlight_run = mode_q[`MCFF_BIT_BL_ON] &&
        mode_q[`MCFF_BIT_ACT];
    assign dim_run = backlight_run && mode_q[`MCFF_BIT_DIM];
    assign level_run = cfg_q[4:3];
    assign gain_step_up = core_enable && gain_up_req;
    assign gain_step_down = core_enable && gain_down_req &&
        (!mode_q[`MCFF_BIT_GDI] || all_leds_off);
    assign independent_sink_run = core_enable && sync_q;
endmodule
`default_nettype wire

//--- src/mcff_defs.svh
/*
 * Register offsets, field positions, reset values and timing counts of
 * the mode control and event flag bank. Included by the bank, flag unit and interrupt timer sources.
 */
`ifndef MCFF_DEFS_SVH
`define MCFF_DEFS_SVH

`define MCFF_ADDR_W 8
`define MCFF_OFS_MODE 8'h01
`define MCFF_OFS_FLAG 8'h02
`define MCFF_OFS_IRQ_EN 8'h03
`define MCFF_OFS_CFG 8'h04
`define MCFF_OFS_SINK 8'h10
`define MCFF_OFS_CCFG 8'h1b

`define MCFF_BIT_BL_ON 0
`define MCFF_BIT_AUTO 1
`define MCFF_BIT_SYNC 2
`define MCFF_BIT_GDI 3
`define MCFF_BIT_DIM 4
`define MCFF_BIT_ACT 5
`define MCFF_BIT_RETRIG 6

`define MCFF_MODE_MASK 8'h7f
`define MCFF_FLAG_MASK 8'h1f
`define MCFF_MODE_RST 8'h00
`define MCFF_FLAG_RST 8'h00
`define MCFF_IRQ_EN_RST 8'h00
`define MCFF_CFG_RST 8'h00
`define MCFF_SINK_RST 8'h00
`define MCFF_CCFG_RST 8'h00

`define MCFF_BLV_LSB 3
`define MCFF_BLV_MASK 8'h18

`define MCFF_CLK_MHZ 100
`define MCFF_GAP_US 50
`define MCFF_GAP_CYC (`MCFF_GAP_US * `MCFF_CLK_MHZ)

`endif

//--- src/mcff_flag_if.sv
/*
 * Interface between the bank top and its event flag unit.
 * Assumes one clock domain owned by the top.
 */
`timescale 1ns/1ps
`default_nettype none
interface mcff_flag_if;
    import mcff_pkg::*;
    mcff_flags_t evt;
    mcff_flags_t clr;
    mcff_flags_t flags;
    modport bank (output evt, output clr, input flags);
    modport unit (input evt, input clr, output flags);
endinterface
`default_nettype wire

//--- src/mcff_flag_unit.sv
/*
 * Sticky event flags, cleared by writing one.
 * Assumes event and clear inputs are one-cycle and synchronous.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mcff_defs.svh"
module mcff_flag_unit
    import mcff_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    mcff_flag_if.unit fl
);
    mcff_flags_t flags_q;
    mcff_flags_t flags_d;

    always_comb
    begin
        // Set beats clear in the same cycle
        flags_d = (flags_q & ~fl.clr) | fl.evt;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            flags_q <= mcff_flags_t'(`MCFF_FLAG_RST);
        else
            flags_q <= flags_d;
    end

    assign fl.flags = flags_q;
endmodule
`default_nettype wire

//--- src/mcff_irq_timer.sv
/*
 * Interrupt output sequencer with optional retrigger gap.
 * Assumes pending and clear strobe are synchronous to clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mcff_defs.svh"
module mcff_irq_timer
    import mcff_pkg::*;
#(
    parameter int unsigned GAP_CYC = `MCFF_GAP_CYC
)
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic pending,
    input wire logic clear_try,
    input wire logic retrigger,
    output logic irq
);
    mcff_irq_state_t st_q;
    mcff_irq_state_t st_d;
    logic [12:0] cnt_q;
    logic [12:0] cnt_d;

    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        case (st_q)
            MCFF_IRQ_IDLE:
            begin
                if (pending)
                    st_d = MCFF_IRQ_ON;
            end
            MCFF_IRQ_ON:
            begin
                if (clear_try && retrigger)
                begin
                    st_d = MCFF_IRQ_GAP;
                    cnt_d = 13'(GAP_CYC - 1);
                end
                else if (!pending)
                    st_d = MCFF_IRQ_IDLE;
            end
            MCFF_IRQ_GAP:
            begin
                // Counted on clk_sys so the gap is exact
                if (cnt_q == 13'h0000)
                    st_d = pending ? MCFF_IRQ_ON : MCFF_IRQ_IDLE;
                else
                    cnt_d = cnt_q - 13'h0001;
            end
            default:
                st_d = MCFF_IRQ_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            st_q <= MCFF_IRQ_IDLE;
            cnt_q <= 13'h0000;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
        end
    end

    assign irq = (st_q == MCFF_IRQ_ON);
endmodule
`default_nettype wire

//--- src/mcff_pkg.sv
/*
 * Types of the mode control and event flag bank.
 * Assumes mcff_defs.svh is on the include path.
 */
package mcff_pkg;
    typedef logic [7:0] mcff_byte_t;
    typedef logic [4:0] mcff_flags_t;
    typedef logic [1:0] mcff_level_t;
    typedef enum logic [1:0] {MCFF_IRQ_IDLE, MCFF_IRQ_ON, MCFF_IRQ_GAP}
        mcff_irq_state_t;
endpackage
